// *** design/asrx_top.sv ***
// Notes on behaviour
// - Transmit invert flips every driven level: idle, break, start, stop.
// - Buffer-to-shifter move sets tx empty flag; enable requests tx interrupt.
// - Tx complete only when shifter and buffer empty, no break/idle pending.
// - 8 or 9 bit characters; ninth-bit field is bit 8 or bit 7 copy.
// - Completed character goes to read buffer, sets rx full, may interrupt.
// - Receiver samples on an oversample tick at sixteen times baud rate.
// - Oversample count resyncs after start bit and on 1-to-0 data change.
// - Start search: zero after three ones; then count sixteen ticks per bit.
// - Verify start at ticks 3,5,7; two or more ones reject and restart.
// - Accepted start with exactly one verify sample high sets noise flag.
// - Data bit is majority of ticks 8-10; disagreement sets noise flag.
// - Start ticks 8-10 do not reject; any one there sets noise flag.
// - Stop majority zero sets framing error; disagreement sets noise flag.
// - Framing error rises with rx full, break characters included.
// - Unread buffer on completion: set overrun, keep old, drop new.
// - Module disabled forces tx empty and tx complete high, masks tx irq.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "asrx_cfg.svh"

module asrx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   always_comb begin
      in_ready = (cnt_r != (AW+1)'(DEPTH));
      out_valid = (cnt_r != '0);
      out_data = mem_r[rp_r];
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      wp_nxt = push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
      rp_nxt = pop ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage needs no reset; contents are qualified by the count
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
endmodule : asrx_fifo

////////////////////////////////////////////////////////////////////////////////

module asrx_top import asrx_pkg::*; #(
   parameter int FIFO_DEPTH = `ASRX_FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   output logic txd,
   output logic tx_irq,
   output logic rx_irq
);
   // Control registers
   logic en_r, en_nxt, inv_r, inv_nxt, nine_r, nine_nxt;
   logic teie_r, teie_nxt, tx_complete_irq_enable_r, tx_complete_irq_enable_nxt, rfie_r, rfie_nxt;
   logic txen_r, txen_nxt, rxen_r, rxen_nxt, sbrk_r, sbrk_nxt, tx8_r, tx8_nxt;
   logic [15:0] baud_r, baud_nxt, bcnt_r, bcnt_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic acc, hit, wr_data, rd_data, tick;
   logic tbe_flag, tc_flag;
   // Transmitter
   logic [10:0] tsh_r, tsh_nxt;
   logic [3:0] tleft_r, tleft_nxt, trt_r, trt_nxt;
   logic tbrk_r, tbrk_nxt, tbe_r, tbe_nxt, txd_r, txd_nxt;
   logic f_valid, f_ready, f_pop;
   asrx_char_s f_in, f_out;
   // Receiver
   logic [2:0] sync_r;
   logic rxf_r, rxf_nxt;
   asrx_rxst_e st_r, st_nxt;
   logic [4:0] rt_r, rt_nxt, cur;
   logic [2:0] hist_r, hist_nxt;
   logic [1:0] smp_r, smp_nxt, vone_r, vone_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [8:0] sh_r, sh_nxt;
   logic nfp_r, nfp_nxt, prev1_r, prev1_nxt, last_r, last_nxt;
   asrx_char_s rbuf_r, rbuf_nxt;
   logic rf_r, rf_nxt, ovr_r, ovr_nxt, nf_r, nf_nxt, fe_r, fe_nxt;
   logic [1:0] vsum;
   logic maj, split, advance, resync, done;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave

   always_comb begin
      acc = psel & penable;
      hit = (paddr == `ASRX_OFS_CTRL1) | (paddr == `ASRX_OFS_CTRL2) |
            (paddr == `ASRX_OFS_STAT1) | (paddr == `ASRX_OFS_DATA) |
            (paddr == `ASRX_OFS_BAUD);
      // Full buffer stalls the bus instead of dropping the write
      pready = !(pwrite & (paddr == `ASRX_OFS_DATA) & !f_ready);
      pslverr = acc & !hit;
      prdata = prdata_r;
      wr_data = acc & pready & pwrite & (paddr == `ASRX_OFS_DATA);
      rd_data = acc & !pwrite & (paddr == `ASRX_OFS_DATA);
      tbe_flag = tbe_r | !en_r;
      tc_flag = (!(tleft_r != '0) & !f_valid & !tbrk_r & !sbrk_r) | !en_r;
      en_nxt = en_r;
      inv_nxt = inv_r;
      nine_nxt = nine_r;
      teie_nxt = teie_r;
      tx_complete_irq_enable_nxt = tx_complete_irq_enable_r;
      rfie_nxt = rfie_r;
      txen_nxt = txen_r;
      rxen_nxt = rxen_r;
      sbrk_nxt = sbrk_r;
      tx8_nxt = tx8_r;
      baud_nxt = baud_r;
      prdata_nxt = prdata_r;
      if (acc & pwrite & (paddr == `ASRX_OFS_CTRL1)) begin
         en_nxt = pwdata[`ASRX_C1_EN];
         inv_nxt = pwdata[`ASRX_C1_INV];
         nine_nxt = pwdata[`ASRX_C1_NINE];
      end
      if (acc & pwrite & (paddr == `ASRX_OFS_CTRL2)) begin
         teie_nxt = pwdata[`ASRX_C2_TEIE];
         tx_complete_irq_enable_nxt = pwdata[`ASRX_C2_TX_COMPLETE_IRQ_ENABLE];
         rfie_nxt = pwdata[`ASRX_C2_RFIE];
         txen_nxt = pwdata[`ASRX_C2_TXEN];
         rxen_nxt = pwdata[`ASRX_C2_RXEN];
         sbrk_nxt = pwdata[`ASRX_C2_SBRK];
         tx8_nxt = pwdata[`ASRX_C2_TX8];
      end
      if (acc & pwrite & (paddr == `ASRX_OFS_BAUD)) begin
         baud_nxt = pwdata[15:0];
      end
      // Read data is captured in the setup cycle
      if (psel & !penable) begin
         prdata_nxt = '0;
         unique case (paddr)
            `ASRX_OFS_CTRL1: begin
               prdata_nxt[`ASRX_C1_EN] = en_r;
               prdata_nxt[`ASRX_C1_INV] = inv_r;
               prdata_nxt[`ASRX_C1_NINE] = nine_r;
            end
            `ASRX_OFS_CTRL2: begin
               prdata_nxt[6:0] = {tx8_r, sbrk_r, rxen_r, txen_r, rfie_r, tx_complete_irq_enable_r, teie_r};
            end
            `ASRX_OFS_STAT1: begin
               prdata_nxt[`ASRX_S1_TBE] = tbe_flag;
               prdata_nxt[`ASRX_S1_TC] = tc_flag;
               prdata_nxt[`ASRX_S1_RF] = rf_r;
               prdata_nxt[`ASRX_S1_OVR] = ovr_r;
               prdata_nxt[`ASRX_S1_NF] = nf_r;
               prdata_nxt[`ASRX_S1_FE] = fe_r;
               prdata_nxt[`ASRX_S1_R8] = rbuf_r.ninth;
            end
            `ASRX_OFS_DATA: prdata_nxt[7:0] = rbuf_r.data;
            `ASRX_OFS_BAUD: prdata_nxt[15:0] = baud_r;
            default: prdata_nxt = '0;
         endcase
      end
      // Oversample tick, one pulse per divisor period
      tick = en_r & (bcnt_r == '0);
      bcnt_nxt = (!en_r | (bcnt_r == '0)) ? baud_r - 16'h0001 : bcnt_r - 16'h0001;
      tx_irq = en_r & ((teie_r & tbe_flag) | (tx_complete_irq_enable_r & tc_flag));
      rx_irq = rfie_r & rf_r;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         en_r <= 1'b0;
         inv_r <= 1'b0;
         nine_r <= 1'b0;
         teie_r <= 1'b0;
         tx_complete_irq_enable_r <= 1'b0;
         rfie_r <= 1'b0;
         txen_r <= 1'b0;
         rxen_r <= 1'b0;
         sbrk_r <= 1'b0;
         tx8_r <= 1'b0;
         baud_r <= `ASRX_BAUD_RST;
         bcnt_r <= '0;
         prdata_r <= '0;
      end else begin
         en_r <= en_nxt;
         inv_r <= inv_nxt;
         nine_r <= nine_nxt;
         teie_r <= teie_nxt;
         tx_complete_irq_enable_r <= tx_complete_irq_enable_nxt;
         rfie_r <= rfie_nxt;
         txen_r <= txen_nxt;
         rxen_r <= rxen_nxt;
         sbrk_r <= sbrk_nxt;
         tx8_r <= tx8_nxt;
         baud_r <= baud_nxt;
         bcnt_r <= bcnt_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter

   assign f_in = '{ninth: tx8_r, data: pwdata[7:0]};

   asrx_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_txq (
      .clk(ref_clk),
      .rst(rst),
      .in_valid(wr_data),
      .in_ready(f_ready),
      .in_data(f_in),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_out)
   );

   always_comb begin
      tsh_nxt = tsh_r;
      tleft_nxt = tleft_r;
      trt_nxt = trt_r;
      tbrk_nxt = tbrk_r;
      f_pop = 1'b0;
      if (!en_r) begin
         tleft_nxt = '0;
         tbrk_nxt = 1'b0;
      end else if (tleft_r == '0) begin
         trt_nxt = '0;
         if (txen_r & sbrk_r) begin
            tsh_nxt = '0;
            tleft_nxt = nine_r ? 4'hB : 4'hA;
            tbrk_nxt = 1'b1;
         end else if (tbrk_r) begin
            // One idle bit after a break marks the next start edge
            tsh_nxt = '1;
            tleft_nxt = 4'h1;
            tbrk_nxt = 1'b0;
         end else if (txen_r & f_valid) begin
            f_pop = 1'b1;
            tsh_nxt = nine_r ? {1'b1, f_out.ninth, f_out.data, 1'b0}
                             : {2'b11, f_out.data, 1'b0};
            tleft_nxt = nine_r ? 4'hB : 4'hA;
         end
      end else if (tick) begin
         trt_nxt = trt_r + 4'h1;
         if (trt_r == 4'hF) begin
            tsh_nxt = {1'b1, tsh_r[10:1]};
            tleft_nxt = tleft_r - 4'h1;
         end
      end
      tbe_nxt = f_pop | (tbe_r & !wr_data);
      txd_nxt = ((tleft_r != '0) ? tsh_r[0] : 1'b1) ^ inv_r;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tsh_r <= '1;
         tleft_r <= '0;
         trt_r <= '0;
         tbrk_r <= 1'b0;
         tbe_r <= 1'b1;
         txd_r <= 1'b1;
      end else begin
         tsh_r <= tsh_nxt;
         tleft_r <= tleft_nxt;
         trt_r <= trt_nxt;
         tbrk_r <= tbrk_nxt;
         tbe_r <= tbe_nxt;
         txd_r <= txd_nxt;
      end
   end

   assign txd = txd_r;

   ////////////////////////////////////////////////////////////////////////////
   // Receiver

   always_comb begin
      // Filtered level changes only when stages two and three agree
      rxf_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : rxf_r;
      st_nxt = st_r;
      rt_nxt = rt_r;
      hist_nxt = hist_r;
      smp_nxt = smp_r;
      vone_nxt = vone_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      nfp_nxt = nfp_r;
      prev1_nxt = prev1_r;
      last_nxt = last_r;
      cur = (rt_r == `ASRX_RT_LAST) ? 5'h01 : rt_r + 5'h01;
      vsum = vone_r + {1'b0, rxf_r};
      maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & rxf_r) | (smp_r[1] & rxf_r);
      split = !((smp_r == 2'b00) & !rxf_r) & !((smp_r == 2'b11) & rxf_r);
      // Falling edge after a decided one, outside the sample window
      resync = prev1_r & last_r & !rxf_r & ((cur > `ASRX_RT_S3) | (cur < `ASRX_RT_S1));
      advance = (cur == `ASRX_RT_LAST) | (resync & (cur > `ASRX_RT_S3));
      done = 1'b0;
      if (!en_r | !rxen_r) begin
         st_nxt = ASRX_IDLE;
         hist_nxt = '0;
      end else if (tick) begin
         last_nxt = rxf_r;
         unique case (st_r)
            ASRX_IDLE: begin
               hist_nxt = {hist_r[1:0], rxf_r};
               if ((hist_r == 3'b111) & !rxf_r) begin
                  st_nxt = ASRX_START;
                  rt_nxt = 5'h01;
                  vone_nxt = '0;
                  nfp_nxt = 1'b0;
                  hist_nxt = '0;
               end
            end
            ASRX_START: begin
               rt_nxt = cur;
               if ((cur == `ASRX_RT_V1) | (cur == `ASRX_RT_V2)) begin
                  vone_nxt = vsum;
               end
               if (cur == `ASRX_RT_V3) begin
                  if (vsum >= 2'h2) begin
                     st_nxt = ASRX_IDLE;
                     rt_nxt = '0;
                  end else if (vsum == 2'h1) begin
                     nfp_nxt = 1'b1;
                  end
               end
               if ((cur >= `ASRX_RT_S1) & (cur <= `ASRX_RT_S3) & rxf_r) begin
                  nfp_nxt = 1'b1;
               end
               if (cur == `ASRX_RT_LAST) begin
                  st_nxt = ASRX_DATA;
                  bit_nxt = '0;
                  prev1_nxt = 1'b0;
               end
            end
            ASRX_DATA, ASRX_STOP: begin
               rt_nxt = resync ? 5'h01 : cur;
               if (resync) begin
                  prev1_nxt = 1'b0;
               end
               if ((cur == `ASRX_RT_S1) | (cur == `ASRX_RT_S2)) begin
                  smp_nxt = {smp_r[0], rxf_r};
               end
               if (cur == `ASRX_RT_S3) begin
                  nfp_nxt = nfp_r | split;
                  if (st_r == ASRX_DATA) begin
                     sh_nxt = {maj, sh_r[8:1]};
                     prev1_nxt = maj;
                     bit_nxt = bit_r + 4'h1;
                  end else begin
                     done = 1'b1;
                     st_nxt = ASRX_IDLE;
                  end
               end
               if (advance & (st_r == ASRX_DATA) & (bit_r == (nine_r ? 4'h9 : 4'h8))) begin
                  st_nxt = ASRX_STOP;
               end
            end
         endcase
      end
      rbuf_nxt = rbuf_r;
      // Set wins over a read in the same cycle
      rf_nxt = rf_r & !rd_data;
      ovr_nxt = ovr_r & !rd_data;
      nf_nxt = nf_r & !rd_data;
      fe_nxt = fe_r & !rd_data;
      if (done) begin
         if (rf_r & !rd_data) begin
            ovr_nxt = 1'b1;
         end else begin
            rbuf_nxt.data = nine_r ? sh_r[7:0] : sh_r[8:1];
            rbuf_nxt.ninth = sh_r[8];
            rf_nxt = 1'b1;
            nf_nxt = nfp_r | split;
            fe_nxt = !maj;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync_r <= 3'b111;
         rxf_r <= 1'b1;
         st_r <= ASRX_IDLE;
         rt_r <= '0;
         hist_r <= '0;
         smp_r <= '0;
         vone_r <= '0;
         bit_r <= '0;
         sh_r <= '0;
         nfp_r <= 1'b0;
         prev1_r <= 1'b0;
         last_r <= 1'b1;
         rbuf_r <= '0;
         rf_r <= 1'b0;
         ovr_r <= 1'b0;
         nf_r <= 1'b0;
         fe_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], rxd};
         rxf_r <= rxf_nxt;
         st_r <= st_nxt;
         rt_r <= rt_nxt;
         hist_r <= hist_nxt;
         smp_r <= smp_nxt;
         vone_r <= vone_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         nfp_r <= nfp_nxt;
         prev1_r <= prev1_nxt;
         last_r <= last_nxt;
         rbuf_r <= rbuf_nxt;
         rf_r <= rf_nxt;
         ovr_r <= ovr_nxt;
         nf_r <= nf_nxt;
         fe_r <= fe_nxt;
      end
   end
endmodule : asrx_top

`default_nettype wire

// *** design/asrx_cfg.svh ***
`ifndef ASRX_CFG_SVH
`define ASRX_CFG_SVH
`define ASRX_OFS_CTRL1 8'h00
`define ASRX_OFS_CTRL2 8'h04
`define ASRX_OFS_STAT1 8'h08
`define ASRX_OFS_DATA 8'h0C
`define ASRX_OFS_BAUD 8'h10
`define ASRX_C1_EN 0
`define ASRX_C1_INV 1
`define ASRX_C1_NINE 2
`define ASRX_C2_TEIE 0
`define ASRX_C2_TX_COMPLETE_IRQ_ENABLE 1
`define ASRX_C2_RFIE 2
`define ASRX_C2_TXEN 3
`define ASRX_C2_RXEN 4
`define ASRX_C2_SBRK 5
`define ASRX_C2_TX8 6
`define ASRX_S1_TBE 0
`define ASRX_S1_TC 1
`define ASRX_S1_RF 2
`define ASRX_S1_OVR 3
`define ASRX_S1_NF 4
`define ASRX_S1_FE 5
`define ASRX_S1_R8 6
`define ASRX_BAUD_RST 16'h006C
`define ASRX_RT_LAST 5'h10
`define ASRX_RT_V1 5'h03
`define ASRX_RT_V2 5'h05
`define ASRX_RT_V3 5'h07
`define ASRX_RT_S1 5'h08
`define ASRX_RT_S2 5'h09
`define ASRX_RT_S3 5'h0A
`define ASRX_FIFO_DEPTH 32
`endif

// *** design/asrx_pkg.sv ***
package asrx_pkg;
   typedef enum logic [1:0] {
      ASRX_IDLE = 2'b00,
      ASRX_START = 2'b01,
      ASRX_DATA = 2'b10,
      ASRX_STOP = 2'b11
   } asrx_rxst_e;
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } asrx_char_s;
endpackage : asrx_pkg

// *** test/asrx_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asrx_cfg.svh"
module asrx_top_sva (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic txd,
   input wire logic tx_irq,
   input wire logic rx_irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic acc, wr_c1, wr_c2, rd_st, rd_dat;
   logic en_r, inv_r, teie_r, tx_complete_irq_enable_r, rfie_r;
   assign acc = psel && penable && pready;
   assign wr_c1 = acc && pwrite && (paddr == `ASRX_OFS_CTRL1);
   assign wr_c2 = acc && pwrite && (paddr == `ASRX_OFS_CTRL2);
   assign rd_st = acc && !pwrite && (paddr == `ASRX_OFS_STAT1);
   assign rd_dat = acc && !pwrite && (paddr == `ASRX_OFS_DATA);
   // Shadow of the control bits, so flags can be tied to the enables
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {en_r, inv_r, teie_r, tx_complete_irq_enable_r, rfie_r} <= 5'h00;
      end else begin
         if (wr_c1) begin
            {inv_r, en_r} <= pwdata[1:0];
         end
         if (wr_c2) begin
            {rfie_r, tx_complete_irq_enable_r, teie_r} <= pwdata[2:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   AST_DIS_NO_TXIRQ: assert property (!en_r |-> !tx_irq)
      else $error("tx_irq high while module disabled");
   // Three disabled cycles: the shifter abort and the output register each take one after the first
   AST_IDLE_POLARITY: assert property (!en_r && !$past(en_r) && !$past(en_r, 2) &&
      $stable(inv_r) |-> txd == !inv_r)
      else $error("idle txd level ignores inversion");
   AST_RXIRQ_GATE: assert property (!rfie_r |-> !rx_irq)
      else $error("rx_irq without its enable");
   AST_RXIRQ_HOLD: assert property (rx_irq && !rd_dat && !wr_c1 && !wr_c2 |=> rx_irq)
      else $error("rx_irq dropped without a data read");
   AST_TE_IRQ: assert property (rd_st && en_r && teie_r && !tx_complete_irq_enable_r |-> prdata[0] == $past(tx_irq))
      else $error("tx empty flag and tx_irq disagree");
   AST_TC_IRQ: assert property (rd_st && en_r && tx_complete_irq_enable_r && !teie_r |-> prdata[1] == $past(tx_irq))
      else $error("tx complete flag and tx_irq disagree");
   AST_RF_IRQ: assert property (rd_st && rfie_r |-> prdata[2] == $past(rx_irq))
      else $error("rx full flag and rx_irq disagree");
   AST_DIS_FLAGS: assert property (rd_st && !en_r |-> prdata[1:0] == 2'b11)
      else $error("disabled module does not show both tx flags");
endmodule : asrx_top_sva

bind asrx_top asrx_top_sva chk_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// *** test/asrx_remote.sv ***
`timescale 1ns/1ps
`default_nettype none
module asrx_remote #(
   parameter int BITC = 64
) (
   input wire logic clk,
   input wire logic txd,
   input wire logic inv,
   input wire logic listen,
   output logic rxd,
   output logic [7:0] got,
   output logic [7:0] got_cnt
);
   initial begin
      rxd = 1'b1;
      got = 8'h00;
      got_cnt = 8'h00;
   end
   // Glitch of one tick width flips exactly one receiver sample
   task automatic send_char(input logic [8:0] d, input int nb, input logic stopv,
                            input int gbit, input int goff);
      logic v;
      for (int k = 0; k < nb + 2; k++) begin
         v = (k == 0) ? 1'b0 : ((k <= nb) ? d[k-1] : stopv);
         for (int c = 0; c < BITC; c++) begin
            rxd <= (k == gbit && c >= goff && c < goff + BITC / 16) ? !v : v;
            @(posedge clk);
         end
      end
      rxd <= 1'b1;
      repeat (2 * BITC) @(posedge clk);
   endtask : send_char
   task automatic pulse_low(input int n);
      rxd <= 1'b0;
      repeat (n) @(posedge clk);
      rxd <= 1'b1;
      repeat (12 * BITC) @(posedge clk);
   endtask : pulse_low
   ////////////////////////////////////////////////////////////////////////////
   // Listener only while armed: a polarity change alone looks like a start
   always begin
      @(posedge clk);
      if (listen && txd === inv) begin
         repeat (BITC / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge clk);
            got[i] <= txd ^ inv;
         end
         repeat (BITC) @(posedge clk);
         got_cnt <= got_cnt + 8'h01;
      end
   end
endmodule : asrx_remote
`default_nettype wire

// *** test/asrx_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asrx_cfg.svh"
module asrx_top_tb import asrx_pkg::*;;
   localparam int BITC = 64;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, rxd, txd, tx_irq, rx_irq;
   logic inv_m, listen, last_err;
   logic [7:0] paddr, got, got_cnt;
   logic [31:0] pwdata, prdata, rd;
   int fails = 0;
   int num_checks = 0;
   logic [8:0] td [8] = '{9'h096, 9'h096, 9'h096, 9'h096, 9'h096, 9'h000, 9'h080, 9'h17F};
   int nb [8] = '{8, 8, 8, 8, 8, 8, 9, 9};
   logic ts [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   int tg [8] = '{-1, 1, 0, 0, -1, -1, -1, -1};
   int tof [8] = '{36, 36, 36, 16, 36, 36, 36, 36};
   logic [7:0] es [8] = '{8'h44, 8'h54, 8'h54, 8'h54, 8'h64, 8'h24, 8'h04, 8'h44};
   logic [7:0] ed [8] = '{8'h96, 8'h96, 8'h96, 8'h96, 8'h96, 8'h00, 8'h80, 8'h7F};
   always #2.5 ref_clk = ~ref_clk;
   asrx_top #(.FIFO_DEPTH(32)) dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq));
   asrx_remote #(.BITC(BITC)) remote_u (.clk(ref_clk), .txd(txd), .inv(inv_m),
      .listen(listen), .rxd(rxd), .got(got), .got_cnt(got_cnt));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Answer taken at the very edge that sees pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask : rdchk
   task automatic wait_tx(input logic [7:0] c0);
      for (int i = 0; i < 20 * BITC && got_cnt == c0; i++) @(posedge ref_clk);
      repeat (2 * BITC) @(posedge ref_clk);
   endtask : wait_tx
   task automatic print_verdict;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////
   // About five and a half times the expected run, so a stall cannot hide
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      print_verdict();
   end
   initial begin
      {psel, penable, pwrite, inv_m, listen} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      rdchk(`ASRX_OFS_STAT1, 32'hFFFFFFFF, 32'h03);
      apb(1'b0, 8'h14, 32'h0);
      chk({rd[30:0], last_err}, 32'h1);
      apb(1'b1, `ASRX_OFS_BAUD, 32'h4);
      apb(1'b1, `ASRX_OFS_CTRL1, 32'h1);
      apb(1'b1, `ASRX_OFS_CTRL2, 32'h1D);
      @(negedge ref_clk);
      chk({31'h0, tx_irq}, 32'h1);
      listen <= 1'b1;
      apb(1'b1, `ASRX_OFS_DATA, 32'hA5);
      wait_tx(8'h00);
      chk({24'h0, got}, 32'hA5);
      rdchk(`ASRX_OFS_STAT1, 32'h3, 32'h3);
      apb(1'b1, `ASRX_OFS_CTRL2, 32'h1E);
      // Disarmed while the idle level flips, or the flip reads as a start
      listen <= 1'b0;
      apb(1'b1, `ASRX_OFS_CTRL1, 32'h3);
      inv_m <= 1'b1;
      repeat (2) @(negedge ref_clk);
      chk({31'h0, txd}, 32'h0);
      @(posedge ref_clk);
      listen <= 1'b1;
      apb(1'b1, `ASRX_OFS_DATA, 32'h3C);
      wait_tx(8'h01);
      chk({24'h0, got}, 32'h3C);
      rdchk(`ASRX_OFS_STAT1, 32'h3, 32'h3);
      listen <= 1'b0;
      inv_m <= 1'b0;
      apb(1'b1, `ASRX_OFS_CTRL2, 32'h1C);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `ASRX_OFS_CTRL1, (nb[i] == 9) ? 32'h5 : 32'h1);
         remote_u.send_char(td[i], nb[i], ts[i], tg[i], tof[i]);
         chk({31'h0, rx_irq}, 32'h1);
         rdchk(`ASRX_OFS_STAT1, 32'h7C, {24'h0, es[i]});
         rdchk(`ASRX_OFS_DATA, 32'hFF, {24'h0, ed[i]});
      end
      rdchk(`ASRX_OFS_STAT1, 32'h3C, 32'h0);
      apb(1'b1, `ASRX_OFS_CTRL1, 32'h1);
      remote_u.pulse_low(8);
      rdchk(`ASRX_OFS_STAT1, 32'h3C, 32'h0);
      remote_u.send_char(9'h011, 8, 1'b1, -1, 36);
      remote_u.send_char(9'h022, 8, 1'b1, -1, 36);
      rdchk(`ASRX_OFS_STAT1, 32'h0C, 32'h0C);
      rdchk(`ASRX_OFS_DATA, 32'hFF, 32'h11);
      apb(1'b1, `ASRX_OFS_CTRL2, 32'h1B);
      // One word goes to the shifter, the next 32 fill the buffer
      for (int i = 0; i < 33; i++) apb(1'b1, `ASRX_OFS_DATA, i);
      rdchk(`ASRX_OFS_STAT1, 32'h3, 32'h0);
      chk({31'h0, tx_irq}, 32'h0);
      fork
         apb(1'b1, `ASRX_OFS_DATA, 32'h5A);
         begin
            repeat (3) @(negedge ref_clk);
            chk({31'h0, pready}, 32'h0);
         end
      join
      apb(1'b1, `ASRX_OFS_CTRL1, 32'h0);
      rdchk(`ASRX_OFS_STAT1, 32'h3, 32'h3);
      chk({31'h0, tx_irq}, 32'h0);
      print_verdict();
   end
endmodule : asrx_top_tb
`default_nettype wire
